// file: hdl/iwd_defines.svh
// Constants for the independent watchdog: offsets, fields, keys, timing
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH

// Register byte offsets
`define IWD_OFF_KEY        8'h00
`define IWD_OFF_RELOAD     8'h04
`define IWD_OFF_STATE      8'h08
`define IWD_OFF_IRQ_STAT   8'h0C
`define IWD_OFF_IRQ_CLR    8'h10
`define IWD_OFF_IRQ_EN     8'h14

// Key codes written to key_command
`define IWD_KEY_START      16'hCCCC
`define IWD_KEY_FEED       16'hAAAA
`define IWD_KEY_UNLOCK     16'h5555

// Field widths, positions and reset values
`define IWD_CNT_W          18
`define IWD_RELOAD_RST     18'h3FFFF
`define IWD_ST_RVU         0
`define IWD_ST_RUN         1
`define IWD_IRQ_ZERO       0
`define IWD_IRQ_APPLY      1
`define IWD_IRQ_W          2

// Timing: system clock and the low-speed counting clock
`define IWD_CLK_HZ         125000000
`define IWD_TICK_HZ        3000

`endif

// file: hdl/iwd_pkg.sv
// Types shared by the independent watchdog design
package iwd_pkg;

    // Run state of the counter; once running it never leaves
    typedef enum logic [0:0] {
        IWD_IDLE = 1'b0,
        IWD_RUN  = 1'b1
    } iwd_run_t;

endpackage

// file: hdl/iwd_tick_div.sv
// Divider producing the one-cycle low-speed counting enable
`timescale 1ns/1ps
module iwd_tick_div #(
    parameter int unsigned DIV = 41666
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;
    logic          tick_r;

    // Free-running divider; the pulse is registered so it is glitch free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    assign tick_o = tick_r;

endmodule

// file: hdl/iwd_top.sv
// Independent watchdog with Wishbone register access
//
// Operation
// R1 - Counter advances on a low-speed 3K enable, independent of CPU activity.
// R2 - Once enabled the counter runs until reset; software cannot stop it.
// R3 - While running, reaching zero raises the system reset request.
// R4 - Counting and reset request continue in every low-power mode.
// R5 - Enabled by start key write or by the flash-loaded start setting.
// R6 - Start key enables counting from the reset value 0x3FFFF.
// R7 - Feed key copies the reload field into the counter.
// R8 - Software must feed before the counter runs out from reload value.
// R9 - Reload register ignores writes until unlock key; wait one cycle after.
// R10 - Any other key value relocks the reload register.
// R11 - Feed key also relocks the reload register.
// R12 - Key register holds 16-bit write-only key, reads back zero.
// R13 - Reload register holds 18-bit field, reset value is full scale.
// R14 - Reload field writable only while update flag is clear.
// R15 - Status bit 0 set while new reload moves to count domain.
// R16 - Status bit 1 reads one while the counter runs.
// R17 - Keys and reload values reach the counter only through a safe handoff; the start key loads the counter directly, without waiting for an enable.
`timescale 1ns/1ps
`include "iwd_defines.svh"
module iwd_top
    import iwd_pkg::*;
#(
    parameter int unsigned TICK_DIV = `IWD_CLK_HZ / `IWD_TICK_HZ
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        flash_start_i,
    output logic             watchdog_reset_request_o,
    output logic             irq_o
);

    // Address match, used by both the read mux and the write decode
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] off);
        reg_hit = (adr[7:2] == off[7:2]);
    endfunction

    // Byte-lane merge of an 18-bit field; upper lane bits beyond 17 drop
    function automatic logic [`IWD_CNT_W-1:0] lane_merge(
        input logic [`IWD_CNT_W-1:0] old_v,
        input logic [31:0]           wdat,
        input logic [3:0]            sel);
        logic [31:0] tmp;
        tmp = {{(32-`IWD_CNT_W){1'b0}}, old_v};
        for (int i = 0; i < 3; i++) begin
            if (sel[i]) begin
                tmp[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        lane_merge = tmp[`IWD_CNT_W-1:0];
    endfunction

    logic                  ack_r;
    logic [31:0]           dat_r;
    logic                  req;
    logic                  wr_acc;
    logic                  key_wr;
    logic [15:0]           key_val;
    logic                  key_start;
    logic                  key_feed;
    logic                  key_unlock;
    logic                  reload_wr;
    logic                  tick;
    iwd_run_t              run_r;
    logic [`IWD_CNT_W-1:0] cnt_r;
    logic [`IWD_CNT_W-1:0] reload_r;
    logic [`IWD_CNT_W-1:0] shadow_r;
    logic                  unlock_r;
    logic                  pend_r;
    logic                  feed_pend_r;
    logic                  rst_req_r;
    logic                  strap_ff1_r;
    logic                  strap_ff2_r;
    logic [1:0]            boot_cnt_r;
    logic                  strap_start;
    logic                  start_go;
    logic                  at_zero;
    logic [`IWD_IRQ_W-1:0] irq_stat_r;
    logic [`IWD_IRQ_W-1:0] irq_en_r;
    logic [`IWD_IRQ_W-1:0] irq_set;
    logic [`IWD_IRQ_W-1:0] irq_clr;
    logic                  irq_r;

    // Low-speed counting enable from the system clock
    iwd_tick_div #(
        .DIV    (TICK_DIV)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)                          // [R1]
    );

    // Bus request decode; a write lands on the edge that sees ack high
    assign req        = wb_cyc_i & wb_stb_i;
    assign wr_acc     = req & wb_we_i & ack_r;
    assign key_wr     = wr_acc & reg_hit(wb_adr_i, `IWD_OFF_KEY)
                        & (wb_sel_i[1:0] == 2'b11);
    assign key_val    = wb_dat_i[15:0];
    assign key_start  = key_wr & (key_val == `IWD_KEY_START);
    assign key_feed   = key_wr & (key_val == `IWD_KEY_FEED);
    assign key_unlock = key_wr & (key_val == `IWD_KEY_UNLOCK);
    // Locked or busy reload register silently drops the write
    assign reload_wr  = wr_acc & reg_hit(wb_adr_i, `IWD_OFF_RELOAD)
                        & unlock_r & ~pend_r;   // [R9] [R14]

    // Single-wait-state acknowledge; drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Read data is captured at request time so it comes from a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req & ~ack_r & ~wb_we_i) begin
            if (reg_hit(wb_adr_i, `IWD_OFF_RELOAD)) begin
                dat_r <= {{(32-`IWD_CNT_W){1'b0}}, reload_r};
            end else if (reg_hit(wb_adr_i, `IWD_OFF_STATE)) begin
                dat_r <= {30'h0, (run_r == IWD_RUN), pend_r}; // [R15] [R16]
            end else if (reg_hit(wb_adr_i, `IWD_OFF_IRQ_STAT)) begin
                dat_r <= {{(32-`IWD_IRQ_W){1'b0}}, irq_stat_r};
            end else if (reg_hit(wb_adr_i, `IWD_OFF_IRQ_EN)) begin
                dat_r <= {{(32-`IWD_IRQ_W){1'b0}}, irq_en_r};
            end else begin
                dat_r <= 32'h0000_0000;         // Key and unmapped [R12]
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Start setting from flash arrives asynchronously; two-stage sync
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_ff1_r <= 1'b0;
            strap_ff2_r <= 1'b0;
        end else begin
            strap_ff1_r <= flash_start_i;
            strap_ff2_r <= strap_ff1_r;
        end
    end

    // Sample the synchronised setting once, after the sync has filled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_cnt_r <= 2'h0;
        end else if (boot_cnt_r != 2'h3) begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
        end
    end

    assign strap_start = (boot_cnt_r == 2'h2) & strap_ff2_r;   // [R5]
    assign start_go    = key_start | strap_start;              // [R5]

    // Unlock window: only the unlock key opens it, every other key shuts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_r <= 1'b0;
        end else if (key_wr) begin
            unlock_r <= key_unlock;             // [R9] [R10] [R11]
        end
    end

    // Software-side reload value; reset is full scale
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_r <= `IWD_RELOAD_RST;        // [R13]
        end else if (reload_wr) begin
            reload_r <= lane_merge(reload_r, wb_dat_i, wb_sel_i); // [R13]
        end
    end

    // Update flag: set by a reload write, cleared when the count domain
    // takes the value on its next enable; a write in that cycle is refused, as the flag is still set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= reload_wr | (pend_r & ~tick);   // [R15] [R17]
        end
    end

    // Count-domain copy of the reload value, only moved on an enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow_r <= `IWD_RELOAD_RST;
        end else if (tick & pend_r) begin
            shadow_r <= reload_r;               // [R17]
        end
    end

    // Feed request is held until the next count enable applies it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feed_pend_r <= 1'b0;
        end else begin
            feed_pend_r <= key_feed | (feed_pend_r & ~tick); // [R7] [R17]
        end
    end

    // Run state: no path back to idle short of a reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r <= IWD_IDLE;
        end else begin
            unique case (run_r)
                IWD_IDLE: begin
                    if (start_go) begin
                        run_r <= IWD_RUN;       // [R6]
                    end
                end
                IWD_RUN: begin
                    run_r <= IWD_RUN;           // [R2]
                end
            endcase
        end
    end

    assign at_zero = (cnt_r == '0);

    // Down-counter. No low-power input exists: the enable never stops,
    // so counting goes on whatever mode the rest of the chip is in.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= `IWD_RELOAD_RST;
        end else if (start_go & (run_r == IWD_IDLE)) begin
            cnt_r <= `IWD_RELOAD_RST;           // [R6]
        end else if (tick & (run_r == IWD_RUN)) begin
            if (feed_pend_r) begin
                cnt_r <= shadow_r;              // [R7]
            end else if (!at_zero) begin
                cnt_r <= cnt_r - 1'b1;          // [R1] [R4]
            end
        end
    end

    // Reset request holds until the system reset takes this block down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_req_r <= 1'b0;
        end else if (tick & (run_r == IWD_RUN) & at_zero
                     & ~feed_pend_r) begin
            rst_req_r <= 1'b1;                  // [R3] [R4]
        end
    end

    assign watchdog_reset_request_o = rst_req_r;

    // Interrupt events: counter hit zero, new reload taken over
    assign irq_set[`IWD_IRQ_ZERO]  = tick & (run_r == IWD_RUN) & at_zero
                                     & ~feed_pend_r;
    assign irq_set[`IWD_IRQ_APPLY] = tick & pend_r;
    assign irq_clr = (wr_acc & reg_hit(wb_adr_i, `IWD_OFF_IRQ_CLR)
                      & wb_sel_i[0]) ? wb_dat_i[`IWD_IRQ_W-1:0]
                                     : {`IWD_IRQ_W{1'b0}};

    // Sticky status; an event in the clearing cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_r <= '0;
        end else if (wr_acc & reg_hit(wb_adr_i, `IWD_OFF_IRQ_EN)
                     & wb_sel_i[0]) begin
            irq_en_r <= wb_dat_i[`IWD_IRQ_W-1:0];
        end
    end

    // Registered level interrupt, one cycle behind the status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end

    assign irq_o = irq_r;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_start_key;
        key_start & (run_r == IWD_IDLE);
    endsequence

    sequence s_loaded_full;
        (run_r == IWD_RUN) & (cnt_r == `IWD_RELOAD_RST);
    endsequence

    key_reads_zero_a: assert property ( // [R12]
        (wb_ack_o & ~wb_we_i & reg_hit(wb_adr_i, `IWD_OFF_KEY))
        |-> (wb_dat_o == 32'h0000_0000))
        else $error("key register read back nonzero");

    run_sticky_a: assert property ( // [R2]
        (run_r == IWD_RUN) |=> (run_r == IWD_RUN))
        else $error("running watchdog stopped");

    start_load_a: assert property ( // [R6]
        s_start_key |=> s_loaded_full)
        else $error("start key did not load full count");

    zero_reset_a: assert property ( // [R3]
        (tick & (run_r == IWD_RUN) & at_zero & ~feed_pend_r)
        |=> watchdog_reset_request_o [*3])
        else $error("zero count gave no held reset request");

    count_down_a: assert property ( // [R4]
        (tick & (run_r == IWD_RUN) & ~feed_pend_r & ~at_zero)
        |=> (cnt_r == $past(cnt_r) - 1'b1))
        else $error("counter did not step down on enable");

    feed_apply_a: assert property ( // [R7]
        (tick & (run_r == IWD_RUN) & feed_pend_r)
        |=> (cnt_r == $past(shadow_r)))
        else $error("feed did not load reload value");

    locked_reload_a: assert property ( // [R9]
        (wr_acc & reg_hit(wb_adr_i, `IWD_OFF_RELOAD) & ~unlock_r)
        |=> $stable(reload_r))
        else $error("locked reload register changed");

    relock_a: assert property ( // [R10]
        (key_wr & ~key_unlock) |=> ~unlock_r)
        else $error("non-unlock key left register open");

    busy_reload_a: assert property ( // [R14]
        (wr_acc & reg_hit(wb_adr_i, `IWD_OFF_RELOAD) & pend_r)
        |=> $stable(reload_r))
        else $error("reload changed while update pending");

    rvu_clear_a: assert property ( // [R15]
        (pend_r & tick & ~reload_wr) |=> ~pend_r ##0 (shadow_r == reload_r))
        else $error("update flag not cleared on transfer");

endmodule

// file: bench/tb_iwd_top.sv
// Self-checking bench for the independent watchdog register interface
`timescale 1ns/1ps
`include "iwd_defines.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    err_total++; $display("Error %s expected %h seen %h", nm, exp, got); \
    end end
module tb_iwd_top;
    // Short tick period keeps the run brief; phases below assume 64
    localparam int unsigned TD    = 64;
    localparam int unsigned LIMIT = 20000;
    localparam logic [31:0] RLV   = 32'h0000_0010;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        flash;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        rreq;
    logic        irq;
    int          err_total;
    int          checks;
    int          cycles;
    int          rel_cnt;
    int          n;

    iwd_top #(.TICK_DIV(TD)) i_iwd_top (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .wb_cyc_i                 (cyc),
        .wb_stb_i                 (stb),
        .wb_we_i                  (we),
        .wb_adr_i                 (adr),
        .wb_sel_i                 (sel),
        .wb_dat_i                 (wdat),
        .wb_dat_o                 (rdat),
        .wb_ack_o                 (ack),
        .flash_start_i            (flash),
        .watchdog_reset_request_o (rreq),
        .irq_o                    (irq)
    );

    // Free-running clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Cycles since reset release, used to place writes just after a tick
    always @(posedge clk_i) begin
        if (rst_i) rel_cnt <= 0;
        else rel_cnt <= rel_cnt + 1;
    end

    // Hang guard: a stuck handshake ends the run as a failure
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One classic cycle; the request holds until ack is sampled high.
    // No local limit: only the hang guard ends a wait for ack.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic key(input logic [15:0] k);
        wr(`IWD_OFF_KEY, {16'h0000, k});
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Align to a quiet point of the tick so a pending flag can be seen
    task automatic after_tick();
        while ((rel_cnt % TD) != 8) @(posedge clk_i);
    endtask

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        flash = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        err_total = 0;
        checks = 0;
        cycles = 0;
        do_reset();
        // Reset values, read-only and unmapped places
        rd(`IWD_OFF_KEY);
        `CHK("key_command", 32'h0000_0000, q)
        rd(`IWD_OFF_RELOAD);
        `CHK("reload_value", 32'h0003_FFFF, q)
        rd(`IWD_OFF_STATE);
        `CHK("watchdog_state", 32'h0000_0000, q)
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20);
        `CHK("unmapped", 32'h0000_0000, q)
        `CHK("reset request", 1'b0, rreq)
        // Protection: locked, broken sequence, feed relocks
        wr(`IWD_OFF_RELOAD, RLV);
        rd(`IWD_OFF_RELOAD);
        `CHK("locked reload", 32'h0003_FFFF, q)
        key(`IWD_KEY_UNLOCK);
        key(16'h1234);
        wr(`IWD_OFF_RELOAD, RLV);
        rd(`IWD_OFF_RELOAD);
        `CHK("relocked reload", 32'h0003_FFFF, q)
        key(`IWD_KEY_UNLOCK);
        key(`IWD_KEY_FEED);
        wr(`IWD_OFF_RELOAD, RLV);
        rd(`IWD_OFF_RELOAD);
        `CHK("fed reload", 32'h0003_FFFF, q)
        // Unlocked write, pending flag, write refused while pending
        after_tick();
        key(`IWD_KEY_UNLOCK);
        wr(`IWD_OFF_RELOAD, RLV);
        rd(`IWD_OFF_STATE);
        `CHK("pending set", 32'h0000_0001, q)
        wr(`IWD_OFF_RELOAD, 32'h0000_0020);
        repeat (2 * TD) @(posedge clk_i);
        rd(`IWD_OFF_STATE);
        `CHK("pending clear", 32'h0000_0000, q)
        rd(`IWD_OFF_RELOAD);
        `CHK("reload kept", RLV, q)
        // Interrupt: sticky status, masked, enabled, cleared
        rd(`IWD_OFF_IRQ_STAT);
        `CHK("irq status", 32'h0000_0002, q)
        `CHK("irq masked", 1'b0, irq)
        wr(`IWD_OFF_IRQ_EN, 32'h0000_0002);
        // Output is registered one cycle behind status and enable
        @(posedge clk_i);
        `CHK("irq enabled", 1'b1, irq)
        wr(`IWD_OFF_IRQ_CLR, 32'h0000_0002);
        rd(`IWD_OFF_IRQ_STAT);
        `CHK("irq cleared", 32'h0000_0000, q)
        `CHK("irq low", 1'b0, irq)
        wr(`IWD_OFF_IRQ_EN, 32'h0000_0001);
        // Start counts from full scale, not from the small reload value
        key(`IWD_KEY_START);
        rd(`IWD_OFF_STATE);
        `CHK("running", 32'h0000_0002, q)
        repeat (20 * TD) @(posedge clk_i);
        `CHK("no early reset", 1'b0, rreq)
        // Feed loads the reload value; running out raises the request
        key(`IWD_KEY_FEED);
        repeat (15 * TD) @(posedge clk_i);
        `CHK("reset before run out", 1'b0, rreq)
        n = 0;
        while (rreq !== 1'b1 && n < 6 * TD) begin
            @(posedge clk_i);
            n++;
        end
        `CHK("reset on zero", 1'b1, rreq)
        repeat (3) @(posedge clk_i);
        `CHK("irq zero", 1'b1, irq)
        rd(`IWD_OFF_IRQ_STAT);
        `CHK("irq zero bit", 1'b1, q[0])
        key(16'h0000);
        rd(`IWD_OFF_STATE);
        `CHK("still running", 32'h0000_0002, q)
        `CHK("request sticks", 1'b1, rreq)
        // Start by the flash-loaded setting
        flash <= 1'b1;
        do_reset();
        `CHK("request cleared", 1'b0, rreq)
        repeat (8) @(posedge clk_i);
        rd(`IWD_OFF_STATE);
        `CHK("flash start", 32'h0000_0002, q)
        finish_test();
    end
endmodule
